// *** rtl/occ_pkg.sv ***
package occ_pkg;

   // ==========================================================
   // bus
   localparam int          ADDR_W       = 8;
   localparam int          DATA_W       = 32;
   localparam logic [31:0] ZERO_WORD    = 32'h0000_0000;

   // ==========================================================
   // register offsets (byte addresses)
   localparam logic [7:0]  OFS_PLL0     = 8'h20;
   localparam logic [7:0]  OFS_PLL1     = 8'h24;
   localparam logic [7:0]  OFS_OSC0     = 8'h28;
   localparam logic [7:0]  OFS_OSC1     = 8'h2c;
   localparam logic [7:0]  OFS_SLOW     = 8'h30;
   localparam logic [7:0]  OFS_IEN_SET  = 8'h40;
   localparam logic [7:0]  OFS_IEN_CLR  = 8'h44;
   localparam logic [7:0]  OFS_IEN_ST   = 8'h48;
   localparam logic [7:0]  OFS_PEND     = 8'h4c;
   localparam logic [7:0]  OFS_PEND_CLR = 8'h50;
   localparam logic [7:0]  OFS_LIVE     = 8'h54;

   // ==========================================================
   // pll control fields
   localparam int          PLL_RUN_B    = 0;
   localparam int          PLL_SEL_B    = 1;
   localparam int          PLL_CNT_LSB  = 24;
   localparam int          PLL_CNT_W    = 6;

   // ==========================================================
   // main oscillator control fields and codes
   localparam int          MOSC_MODE_LSB = 0;
   localparam int          MOSC_SU_LSB   = 8;
   localparam int          CODE_W        = 3;
   localparam logic [2:0]  MODE_EXT      = 3'h0;
   localparam int          MODE_XTAL_B   = 2;
   localparam logic [2:0]  SU_RESERVED   = 3'h7;

   // ==========================================================
   // slow oscillator control fields, codes, reset value
   localparam int          SLOW_RUN_B    = 0;
   localparam int          SLOW_MODE_LSB = 8;
   localparam int          SLOW_SU_LSB   = 16;
   localparam logic [2:0]  SLOW_MODE_XTAL = 3'h1;
   localparam logic [31:0] SLOW_RST      = 32'h0001_0000;

   // ==========================================================
   // interrupt source bits
   localparam int          B_PLL0_LOCK  = 0;
   localparam int          B_PLL1_LOCK  = 1;
   localparam int          B_CLK_DONE   = 5;
   localparam int          B_GATE_DONE  = 6;
   localparam int          B_OSC0       = 7;
   localparam int          B_OSC1       = 8;
   localparam int          B_SLOW       = 9;
   localparam int          B_BOD        = 16;
   localparam logic [31:0] IRQ_USED     = 32'h0001_03e3;
   localparam logic [31:0] CLR_IGNORED  = 32'h0000_0020;

   // ==========================================================
   // startup counts in rc oscillator cycles
   localparam int          CNT_W        = 20;

   function automatic logic [CNT_W-1:0] main_su_cycles(input logic [2:0] code);
      logic [CNT_W-1:0] c;
      c = 20'h00000;
      unique case (code)
         3'h0: c = 20'h00000;
         3'h1: c = 20'h00040;
         3'h2: c = 20'h00080;
         3'h3: c = 20'h00800;
         3'h4: c = 20'h01000;
         3'h5: c = 20'h02000;
         3'h6: c = 20'h04000;
         3'h7: c = 20'hfffff;
      endcase
      return c;
   endfunction

   function automatic logic [CNT_W-1:0] slow_su_cycles(input logic [2:0] code);
      logic [CNT_W-1:0] c;
      c = 20'h00000;
      unique case (code)
         3'h0: c = 20'h00000;
         3'h1: c = 20'h00080;
         3'h2: c = 20'h02000;
         3'h3: c = 20'h04000;
         3'h4: c = 20'h10000;
         3'h5: c = 20'h20000;
         3'h6: c = 20'h40000;
         3'h7: c = 20'h80000;
      endcase
      return c;
   endfunction

   // ==========================================================
   // state
   typedef struct packed {
      logic                        ack;
      logic [31:0]                 dat;
      logic                        irq;
      logic [1:0]                  pll_run;
      logic [1:0]                  pll_sel;
      logic [1:0][PLL_CNT_W-1:0]   pll_cnt;
      logic [1:0][PLL_CNT_W-1:0]   pll_wait;
      logic [1:0]                  pll_lock;
      logic [1:0][2:0]             osc_mode;
      logic [1:0][2:0]             osc_su;
      logic [1:0][CNT_W-1:0]       osc_cnt;
      logic [1:0]                  osc_rdy;
      logic [31:0]                 mask;
      logic [31:0]                 pend;
      logic [31:0]                 live_q;
   } occ_state_t;

   typedef struct packed {
      logic                        run;
      logic [2:0]                  mode;
      logic [2:0]                  su;
      logic [CNT_W-1:0]            cnt;
      logic                        rdy;
      logic                        xtal;
   } occ_slow_t;

endpackage

// *** rtl/occ_top.sv ***
// Behaviour
// - each pll takes its reference from main oscillator zero when its select bit is 0, from one when 1.
// - a main oscillator waits 0, 64, 128, 2048, 4096, 8192 or 16384 rc cycles for startup codes 0 to 6; code 7 is reserved.
// - main oscillator mode 0 takes an external clock on the input pin and frees the output pin for i/o.
// - main oscillator modes 4 to 7 drive a crystal across both pins with gain zero to three.
// - the slow oscillator waits 0, 128, 8192, 16384, 65536, 131072, 262144 or 524288 rc cycles for codes 0 to 7.
// - slow oscillator mode 1 drives a crystal, mode 0 takes an external clock and frees the output pin.
// - the slow oscillator runs only while bit 0 of its control register is set.
// - the slow oscillator control register is set to 0x00010000 only by power-on reset.
// - writing ones to the enable-set register sets the matching mask bits of used sources only, zeros do nothing.
// - writing ones to the enable-clear register clears the matching mask bits, zeros do nothing.
// - the read-only mask register shows 1 for each enabled source and resets to zero.
// - sources sit at pll0 lock 0, pll1 lock 1, clock ready 5, gating done 6, osc0 7, osc1 8, slow 9, brown-out 16.
// - a pending bit is set on a rising edge of its live status flag.
// - writing ones to the pending-clear register clears the matching pending bits, except clock ready bit 5, which it ignores.
// - a pll lock rises only after its settle count of slow clock ticks after a write or sleep-exit re-enable.
`timescale 1ns/1ps
`default_nettype none

module occ_top (
   input  wire logic                       i_clock,
   input  wire logic                       i_rst_b,
   input  wire logic                       i_por_b,
   input  wire logic                       i_wb_cyc,
   input  wire logic                       i_wb_stb,
   input  wire logic                       i_wb_we,
   input  wire logic [occ_pkg::ADDR_W-1:0] i_wb_adr,
   input  wire logic [3:0]                 i_wb_sel,
   input  wire logic [occ_pkg::DATA_W-1:0] i_wb_dat,
   output logic                            o_wb_ack,
   output logic      [occ_pkg::DATA_W-1:0] o_wb_dat,
   input  wire logic                       i_rc_tick,
   input  wire logic                       i_slow_tick,
   input  wire logic                       i_sleep_exit,
   input  wire logic                       i_clock_switch_done,
   input  wire logic                       i_gating_done,
   input  wire logic                       i_brownout_seen,
   output logic      [1:0]                 o_pll_run,
   output logic      [1:0]                 o_pll_ref_select,
   output logic      [1:0]                 o_pll_locked,
   output logic      [1:0]                 o_main_osc_xtal,
   output logic      [1:0]                 o_main_osc0_gain,
   output logic      [1:0]                 o_main_osc1_gain,
   output logic      [1:0]                 o_main_osc_stable,
   output logic                            o_slow_osc_run,
   output logic                            o_slow_osc_xtal,
   output logic                            o_slow_osc_stable,
   output logic                            o_irq
);
   import occ_pkg::*;

   // ==========================================================
   // byte lane mask
   function automatic logic [31:0] lane_mask(input logic [3:0] sel);
      logic [31:0] m;
      m = ZERO_WORD;
      for (int b = 0; b < 4; b++) begin
         m[b*8 +: 8] = {8{sel[b]}};
      end
      return m;
   endfunction

   occ_state_t st;
   occ_state_t next_st;
   occ_slow_t  sl;
   occ_slow_t  next_sl;

   logic        req;
   logic        wr_now;
   logic [31:0] wmask;
   logic [31:0] wval;
   logic [31:0] live;
   logic [31:0] clr_bits;
   logic [31:0] rdata;
   logic [1:0]  pll_wr;
   logic [1:0]  osc_wr;
   logic        slow_wr;
   logic [31:0] reg_pll  [2];
   logic [31:0] reg_osc  [2];
   logic [31:0] reg_slow;

   // ==========================================================
   // bus decode
   assign req    = i_wb_cyc & i_wb_stb;
   assign wr_now = req & i_wb_we & st.ack;
   assign wmask  = lane_mask(i_wb_sel);
   assign wval   = i_wb_dat & wmask;

   always_comb begin
      for (int k = 0; k < 2; k++) begin
         reg_pll[k] = ZERO_WORD;
         reg_pll[k][PLL_RUN_B] = st.pll_run[k];
         reg_pll[k][PLL_SEL_B] = st.pll_sel[k];
         reg_pll[k][PLL_CNT_LSB +: PLL_CNT_W] = st.pll_cnt[k];
         reg_osc[k] = ZERO_WORD;
         reg_osc[k][MOSC_MODE_LSB +: CODE_W] = st.osc_mode[k];
         reg_osc[k][MOSC_SU_LSB +: CODE_W] = st.osc_su[k];
      end
      reg_slow = ZERO_WORD;
      reg_slow[SLOW_RUN_B] = sl.run;
      reg_slow[SLOW_MODE_LSB +: CODE_W] = sl.mode;
      reg_slow[SLOW_SU_LSB +: CODE_W] = sl.su;
   end

   always_comb begin
      pll_wr[0] = wr_now & (i_wb_adr == OFS_PLL0);
      pll_wr[1] = wr_now & (i_wb_adr == OFS_PLL1);
      osc_wr[0] = wr_now & (i_wb_adr == OFS_OSC0);
      osc_wr[1] = wr_now & (i_wb_adr == OFS_OSC1);
      slow_wr   = wr_now & (i_wb_adr == OFS_SLOW);
   end

   // ==========================================================
   // read mux, unmapped and write-only offsets read zero
   always_comb begin
      unique case (i_wb_adr)
         OFS_PLL0:   rdata = reg_pll[0];
         OFS_PLL1:   rdata = reg_pll[1];
         OFS_OSC0:   rdata = reg_osc[0];
         OFS_OSC1:   rdata = reg_osc[1];
         OFS_SLOW:   rdata = reg_slow;
         OFS_IEN_ST: rdata = st.mask;
         OFS_PEND:   rdata = st.pend;
         OFS_LIVE:   rdata = st.live_q;
         default:    rdata = ZERO_WORD;
      endcase
   end

   // ==========================================================
   // live status flags
   always_comb begin
      live           = ZERO_WORD;
      live[B_PLL0_LOCK] = st.pll_lock[0];
      live[B_PLL1_LOCK] = st.pll_lock[1];
      live[B_CLK_DONE]  = i_clock_switch_done;
      live[B_GATE_DONE] = i_gating_done;
      live[B_OSC0]   = st.osc_rdy[0];
      live[B_OSC1]   = st.osc_rdy[1];
      live[B_SLOW]   = sl.rdy;
      live[B_BOD]    = i_brownout_seen;
   end

   assign clr_bits = (wr_now && i_wb_adr == OFS_PEND_CLR) ?
                     (wval & ~CLR_IGNORED) : ZERO_WORD;

   // ==========================================================
   // next state
   always_comb begin
      next_st = st;
      next_sl = sl;

      // bus handshake: ack one cycle, data latched with it
      next_st.ack = req & ~st.ack;
      next_st.dat = (req & ~st.ack) ? rdata : ZERO_WORD;

      // main oscillators
      for (int k = 0; k < 2; k++) begin
         if (osc_wr[k]) begin
            next_st.osc_mode[k] = (reg_osc[k][MOSC_MODE_LSB +: CODE_W] & ~wmask[2:0])
                                  | wval[MOSC_MODE_LSB +: CODE_W];
            next_st.osc_su[k]   = (reg_osc[k][MOSC_SU_LSB +: CODE_W]
                                   & ~wmask[MOSC_SU_LSB +: CODE_W])
                                  | wval[MOSC_SU_LSB +: CODE_W];
            next_st.osc_cnt[k]  = '0;
            next_st.osc_rdy[k]  = 1'b0;
         end else if (!(st.osc_mode[k] == MODE_EXT || st.osc_mode[k][MODE_XTAL_B])) begin
            next_st.osc_cnt[k]  = '0;                                    // reserved mode idles
            next_st.osc_rdy[k]  = 1'b0;
         end else if (!st.osc_rdy[k] && st.osc_su[k] != SU_RESERVED) begin
            if (st.osc_cnt[k] >= main_su_cycles(st.osc_su[k])) begin
               next_st.osc_rdy[k] = 1'b1;
            end else if (i_rc_tick) begin
               next_st.osc_cnt[k] = st.osc_cnt[k] + 20'h00001;
            end
         end
      end

      // plls
      for (int k = 0; k < 2; k++) begin
         if (pll_wr[k]) begin
            next_st.pll_run[k] = (st.pll_run[k] & ~wmask[PLL_RUN_B]) | wval[PLL_RUN_B];
            next_st.pll_sel[k] = (st.pll_sel[k] & ~wmask[PLL_SEL_B]) | wval[PLL_SEL_B];
            next_st.pll_cnt[k] = (st.pll_cnt[k] & ~wmask[PLL_CNT_LSB +: PLL_CNT_W])
                                 | wval[PLL_CNT_LSB +: PLL_CNT_W];
            next_st.pll_wait[k] = '0;
            next_st.pll_lock[k] = 1'b0;
         end else if (!st.pll_run[k] || i_sleep_exit) begin
            next_st.pll_wait[k] = '0;
            next_st.pll_lock[k] = 1'b0;
         end else if (!st.pll_lock[k] && st.osc_rdy[st.pll_sel[k]]) begin
            if (st.pll_wait[k] >= st.pll_cnt[k]) begin
               next_st.pll_lock[k] = 1'b1;
            end else if (i_slow_tick) begin
               next_st.pll_wait[k] = st.pll_wait[k] + 6'h01;
            end
         end
      end

      // slow oscillator
      if (slow_wr) begin
         next_sl.run  = (sl.run & ~wmask[SLOW_RUN_B]) | wval[SLOW_RUN_B];
         next_sl.mode = (sl.mode & ~wmask[SLOW_MODE_LSB +: CODE_W])
                        | wval[SLOW_MODE_LSB +: CODE_W];
         next_sl.su   = (sl.su & ~wmask[SLOW_SU_LSB +: CODE_W])
                        | wval[SLOW_SU_LSB +: CODE_W];
         next_sl.cnt  = '0;
         next_sl.rdy  = 1'b0;
      end else if (!sl.run || !(sl.mode == MODE_EXT || sl.mode == SLOW_MODE_XTAL)) begin
         next_sl.cnt  = '0;
         next_sl.rdy  = 1'b0;
      end else if (!sl.rdy) begin
         if (sl.cnt >= slow_su_cycles(sl.su)) begin
            next_sl.rdy = 1'b1;
         end else if (i_rc_tick) begin
            next_sl.cnt = sl.cnt + 20'h00001;
         end
      end
      next_sl.xtal = next_sl.run & (next_sl.mode == SLOW_MODE_XTAL);

      // interrupt mask, set and clear
      if (wr_now && i_wb_adr == OFS_IEN_SET) begin
         next_st.mask = st.mask | (wval & IRQ_USED);
      end else if (wr_now && i_wb_adr == OFS_IEN_CLR) begin
         next_st.mask = st.mask & ~wval;
      end

      // pending bits: a rising edge wins over a clear in the same cycle
      next_st.live_q = live;
      next_st.pend   = ((st.pend & ~clr_bits) | (live & ~st.live_q)) & IRQ_USED;
      next_st.irq    = |(next_st.pend & next_st.mask);
   end

   // ==========================================================
   // registers
   always_ff @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   always_ff @(posedge i_clock or negedge i_por_b) begin
      if (!i_por_b) begin
         sl.run  <= SLOW_RST[SLOW_RUN_B];
         sl.mode <= SLOW_RST[SLOW_MODE_LSB +: CODE_W];
         sl.su   <= SLOW_RST[SLOW_SU_LSB +: CODE_W];
         sl.cnt  <= '0;
         sl.rdy  <= 1'b0;
         sl.xtal <= 1'b0;
      end else begin
         sl <= next_sl;
      end
   end

   // ==========================================================
   // outputs
   assign o_wb_ack          = st.ack;
   assign o_wb_dat          = st.dat;
   assign o_irq             = st.irq;
   assign o_pll_run         = st.pll_run;
   assign o_pll_ref_select  = st.pll_sel;
   assign o_pll_locked      = st.pll_lock;
   assign o_main_osc_xtal   = {st.osc_mode[1][MODE_XTAL_B],
                               st.osc_mode[0][MODE_XTAL_B]};
   assign o_main_osc0_gain  = st.osc_mode[0][1:0];
   assign o_main_osc1_gain  = st.osc_mode[1][1:0];
   assign o_main_osc_stable = st.osc_rdy;
   assign o_slow_osc_run    = sl.run;
   assign o_slow_osc_xtal   = sl.xtal;
   assign o_slow_osc_stable = sl.rdy;

endmodule

`default_nettype wire

// *** tb/occ_tick_src.sv ***
`timescale 1ns/1ps
`default_nettype none
// ===========================
// rc and slow tick source, rate set by divider
module occ_tick_src (
   input  wire logic       i_clock,
   input  wire logic       i_rst_b,
   input  wire logic [3:0] i_rc_div,
   input  wire logic [3:0] i_slow_div,
   output logic            o_rc_tick,
   output logic            o_slow_tick
);
   logic [3:0] rc_c;
   logic [3:0] sl_c;
   always_ff @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
         rc_c        <= 4'h0;
         sl_c        <= 4'h0;
         o_rc_tick   <= 1'b0;
         o_slow_tick <= 1'b0;
      end else begin
         rc_c        <= (rc_c >= i_rc_div) ? 4'h0 : rc_c + 4'h1;
         sl_c        <= (sl_c >= i_slow_div) ? 4'h0 : sl_c + 4'h1;
         o_rc_tick   <= (rc_c == 4'h0);
         o_slow_tick <= (sl_c == 4'h0);
      end
   end
endmodule
`default_nettype wire

// *** tb/occ_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
// ===========================
// port checks
module occ_monitor (
   input  wire logic        i_clock,
   input  wire logic        i_rst_b,
   input  wire logic        i_por_b,
   input  wire logic        i_wb_cyc,
   input  wire logic        i_wb_stb,
   input  wire logic        i_wb_we,
   input  wire logic [7:0]  i_wb_adr,
   input  wire logic        o_wb_ack,
   input  wire logic [31:0] o_wb_dat,
   input  wire logic        i_sleep_exit,
   input  wire logic [1:0]  o_pll_run,
   input  wire logic [1:0]  o_pll_locked,
   input  wire logic [1:0]  o_main_osc_stable,
   input  wire logic        o_slow_osc_run,
   input  wire logic        o_slow_osc_xtal,
   input  wire logic        o_slow_osc_stable,
   input  wire logic        o_irq
);
   default clocking @(posedge i_clock); endclocking
   default disable iff (!i_rst_b || !i_por_b);
   sequence s_req;
      i_wb_cyc && i_wb_stb && !o_wb_ack;
   endsequence
   sequence s_pulse;
      o_wb_ack ##1 !o_wb_ack;
   endsequence
   chk_ack_pulse: assert property (s_req |=> s_pulse) else $error("ack not a single pulse");
   chk_ack_cause: assert property (o_wb_ack |-> $past(i_wb_cyc) && $past(i_wb_stb))
      else $error("ack without request");
   chk_dat_idle: assert property (!o_wb_ack |-> o_wb_dat == 32'h0) else $error("data without ack");
   chk_irq_fall: assert property ($fell(o_irq) |-> $past(o_wb_ack) && $past(i_wb_we))
      else $error("irq dropped without write");
   chk_osc_clear: assert property (o_wb_ack && i_wb_we && i_wb_adr == 8'h28 |=>
      !o_main_osc_stable[0]) else $error("osc0 ready kept over write");
   chk_pll_stop: assert property (!o_pll_run[0] && !$past(o_pll_run[0]) |-> !o_pll_locked[0])
      else $error("lock while pll stopped");
   chk_lock_run: assert property ($rose(o_pll_locked[0]) |-> o_pll_run[0])
      else $error("lock rose while stopped");
   chk_exit_drop: assert property (i_sleep_exit |=> !o_pll_locked[0])
      else $error("lock kept over sleep exit");
   chk_slow_xtal: assert property (o_slow_osc_xtal |-> o_slow_osc_run)
      else $error("slow crystal driven while off");
   chk_slow_off: assert property (!o_slow_osc_run && !$past(o_slow_osc_run) |-> !o_slow_osc_stable)
      else $error("slow ready while off");
endmodule
bind occ_top occ_monitor u_mon (.i_clock(i_clock), .i_rst_b(i_rst_b), .i_por_b(i_por_b),
   .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr),
   .o_wb_ack(o_wb_ack), .o_wb_dat(o_wb_dat), .i_sleep_exit(i_sleep_exit), .o_pll_run(o_pll_run),
   .o_pll_locked(o_pll_locked), .o_main_osc_stable(o_main_osc_stable),
   .o_slow_osc_run(o_slow_osc_run), .o_slow_osc_xtal(o_slow_osc_xtal),
   .o_slow_osc_stable(o_slow_osc_stable), .o_irq(o_irq));
`default_nettype wire

// *** tb/occ_top_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
// ===========================
// stimulus and checks
module occ_top_tb;
   import occ_pkg::*;
   localparam logic [31:0] USED = 32'h0001_03e3;
   logic        clk, rst_b, por_b, cyc, stb, we, slp, ack, irq, srun, sxt, sst, rct, slt;
   logic [7:0]  adr;
   logic [3:0]  sel, rcd, sld;
   logic [31:0] wdat, rdat, q, r, mask_m;
   logic [2:0]  flg;
   logic [1:0]  prun, psel, plk, mxt, g0, g1, mst;
   int          error_cnt, compares, n;
   occ_top uut (.i_clock(clk), .i_rst_b(rst_b), .i_por_b(por_b), .i_wb_cyc(cyc), .i_wb_stb(stb),
      .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_ack(ack),
      .o_wb_dat(rdat), .i_rc_tick(rct), .i_slow_tick(slt), .i_sleep_exit(slp),
      .i_clock_switch_done(flg[2]), .i_gating_done(flg[0]), .i_brownout_seen(flg[1]),
      .o_pll_run(prun), .o_pll_ref_select(psel), .o_pll_locked(plk), .o_main_osc_xtal(mxt),
      .o_main_osc0_gain(g0), .o_main_osc1_gain(g1), .o_main_osc_stable(mst),
      .o_slow_osc_run(srun), .o_slow_osc_xtal(sxt), .o_slow_osc_stable(sst), .o_irq(irq));
   occ_tick_src u_src (.i_clock(clk), .i_rst_b(por_b), .i_rc_div(rcd), .i_slow_div(sld),
      .o_rc_tick(rct), .o_slow_tick(slt));
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      k = 0;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do begin
         @(posedge clk);
         k++;
      end while (ack !== 1'b1 && k < 20);
      chk("ack", ack, 32'h1);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
      bus(1'b0, a, 32'h0);
      chk(nm, q, e);
   endtask
   task automatic wait_rdy(input int w, output int t);
      t = 0;
      for (int i = 0; i < 3000; i++) begin
         @(posedge clk);
         if ((w == 2) ? slt : rct) t++;
         if ((w == 0 && mst[1]) || (w == 1 && sst) || (w == 2 && plk[0])) break;
      end
   endtask
   task automatic complete_run();
      $display("compares %0d mismatches %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   initial begin
      repeat (30000) @(posedge clk);
      error_cnt++;
      complete_run();
   end
   initial begin
      {cyc, stb, we, slp, adr, wdat, flg, q, mask_m, error_cnt, compares} = '0;
      {rst_b, por_b, sel, rcd, sld, r} = {2'b00, 4'hf, 4'h1, 4'h3, 32'd57};
      repeat (12) @(posedge clk);
      rst_b <= 1'b1;
      por_b <= 1'b1;
      @(posedge clk);
      rd(8'h30, 32'h0001_0000, "slow ctl");
      rd(8'h48, 32'h0, "mask");
      rd(8'h28, 32'h0, "osc0 ctl");
      rd(8'h40, 32'h0, "wo read");
      rd(8'h80, 32'h0, "unmapped");
      $display("test reset done");
      for (int i = 0; i < 6; i++) begin
         r = lfsr(r);
         bus(1'b1, 8'h40, r);
         mask_m = mask_m | (r & USED);
         r = lfsr(r);
         bus(1'b1, 8'h44, r);
         mask_m = mask_m & ~r;
         rd(8'h48, mask_m, "mask");
      end
      bus(1'b1, 8'h48, 32'hffff_ffff);
      rd(8'h48, mask_m, "mask ro");
      bus(1'b1, 8'h40, 32'hffff_ffff);
      bus(1'b1, 8'h50, 32'hffff_ffff);
      rd(8'h4c, 32'h0, "pend clr");
      chk("irq idle", irq, 32'h0);
      $display("test mask done");
      for (int i = 0; i < 3; i++) begin
         n = (i == 0) ? 6 : (i == 1) ? 16 : 5;
         flg[i] <= 1'b1;
         repeat (3) @(posedge clk);
         rd(8'h4c, 32'h1 << n, "pend set");
         chk("irq on", irq, 32'h1);
         bus(1'b1, 8'h44, 32'h1 << n);
         chk("irq masked", irq, 32'h0);
         bus(1'b1, 8'h40, 32'h1 << n);
         chk("irq unmasked", irq, 32'h1);
         bus(1'b1, 8'h50, 32'h1 << n);
         rd(8'h4c, (n == 5) ? 32'h20 : 32'h0, "pend clr");
         chk("irq clr", irq, 32'(n == 5));
         flg[i] <= 1'b0;
      end
      bus(1'b1, 8'h44, 32'h20);
      $display("test irq done");
      for (int m = 0; m < 8; m++) begin
         bus(1'b1, 8'h28, 32'(m));
         repeat (2) @(posedge clk);
         chk("xtal", mxt[0], 32'(m >= 4));
         chk("gain", g0, 32'(m % 4));
         chk("ready", mst[0], 32'(m == 0 || m >= 4));
      end
      rd(8'h4c, 32'ha0, "osc0 pend");
      bus(1'b1, 8'h28, 32'h0000_0704);
      repeat (20) @(posedge clk);
      chk("su reserved", {mxt[0], g0, mst[0]}, 32'h8);
      bus(1'b1, 8'h2c, 32'h0000_0205);
      wait_rdy(0, n);
      chk("osc1 startup", 32'(n >= 127 && n <= 131), 32'h1);
      chk("osc1 mode", {mxt[1], g1}, 32'h5);
      bus(1'b1, 8'h30, 32'h0001_0101);
      chk("slow xtal", sxt, 32'h1);
      wait_rdy(1, n);
      chk("slow startup", 32'(n >= 127 && n <= 131), 32'h1);
      chk("slow ready", sst, 32'h1);
      rst_b <= 1'b0;
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      rd(8'h30, 32'h0001_0101, "slow kept");
      bus(1'b1, 8'h30, 32'h0);
      repeat (2) @(posedge clk);
      chk("slow off", {srun, sxt, sst}, 32'h0);
      $display("test osc done");
      bus(1'b1, 8'h20, 32'h0300_0003);
      chk("pll src", psel[0], 32'h1);
      wait_rdy(2, n);
      chk("pll settle", 32'(n >= 2 && n <= 5 && plk[0]), 32'h1);
      slp <= 1'b1;
      @(posedge clk);
      slp <= 1'b0;
      @(posedge clk);
      chk("exit drop", plk[0], 32'h0);
      wait_rdy(2, n);
      chk("exit relock", 32'(n >= 2 && n <= 5 && plk[0]), 32'h1);
      bus(1'b1, 8'h20, 32'h0300_0001);
      chk("pll src0", psel[0], 32'h0);
      bus(1'b1, 8'h20, 32'h0);
      repeat (2) @(posedge clk);
      chk("pll off", {prun[0], plk[0]}, 32'h0);
      bus(1'b1, 8'h2c, 32'h1);
      bus(1'b1, 8'h20, 32'h0100_0003);
      repeat (60) @(posedge clk);
      chk("no src lock", plk[0], 32'h0);
      $display("test pll done");
      complete_run();
   end
endmodule
`default_nettype wire
